// ---- verilog/asrc_pkg.sv ----
// Package: timing constants, pin bundle and request types for the SRAM controller
package asrc_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 19;
  localparam int DATA_W = 8;
  localparam int CLK_PERIOD_NS = 10;

  // ----------------------------------------------------------------
  // Timing limits in ns, index 0 fast grade, index 1 slow grade
  // ----------------------------------------------------------------
  localparam int READ_CYCLE_MIN_NS [2] = '{55, 70};
  localparam int ADDRESS_TO_DATA_MAX_NS [2] = '{55, 70};
  localparam int OE_TO_DATA_MAX_NS [2] = '{25, 35};
  localparam int RELEASE_MAX_NS [2] = '{20, 25};
  localparam int WRITE_CYCLE_MIN_NS [2] = '{55, 70};
  localparam int CS_TO_WRITE_END_MIN_NS [2] = '{45, 60};
  localparam int ADDR_TO_WRITE_END_MIN_NS [2] = '{45, 60};
  localparam int WRITE_PULSE_MIN_NS [2] = '{40, 50};
  localparam int DATA_SETUP_TO_WRITE_END_NS [2] = '{25, 30};
  localparam int WRITE_TO_HIGHZ_MAX_NS = 20;

  // Least time rounds up to whole cycles, never below one
  function automatic int minCycles(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  // Round-up to cover a longest delay of the far side before sampling
  function automatic int waitCycles(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ASRC_IDLE  = 3'b000,
    ASRC_RADDR = 3'b001,
    ASRC_RDONE = 3'b010,
    ASRC_WPULSE = 3'b011,
    ASRC_WEND  = 3'b100,
    ASRC_TURN  = 3'b101
  } asrc_state_e;

  // Pins toward the SRAM, strobes active low
  typedef struct packed {
    logic [ADDR_W-1:0] addressLines;
    logic chipSelN;
    logic writeStrobeN;
    logic outEnableN;
    logic [DATA_W-1:0] dataLinesOut;
    logic dataLinesOe;
  } asrc_pins_s;

  // User request
  typedef struct packed {
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } asrc_req_s;

  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;

endpackage

// ---- verilog/asrc_sync.sv ----
// Two-flip-flop synchroniser for a bus of pin inputs
`timescale 1ns/10ps
module asrc_sync
  import asrc_pkg::*;
#(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Data
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] stage1_reg;

  // ----------------------------------------------------------------
  // Synchroniser, first stage feeds only the second
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      stage1_reg <= '0;
      dout <= '0;
    end else begin
      stage1_reg <= din;
      dout <= stage1_reg;
    end
  end

endmodule

// ---- verilog/asrc_ctrl.sv ----
// Host-side controller for an asynchronous 512K x 8 static RAM
`timescale 1ns/10ps
// Notes on behaviour
// - Read cycle no shorter than grade minimum
// - Write spans overlap of select and strobe
// - Write cycle no shorter than grade minimum
// - Select low long enough before write end
// - Address stable from write start onward
// - Write pulse no shorter than grade minimum
// - Address may change right at write end
// - Write data set up, held to end
module asrc_ctrl
  import asrc_pkg::*;
#(
  parameter int SLOW_GRADE = 0
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // User request
  input wire logic reqValid,
  input wire asrc_req_s reqData,
  output logic reqReady,
  // User answer
  output logic rspValid,
  output logic [DATA_W-1:0] rspData,
  // SRAM pins
  output asrc_pins_s pins,
  input wire logic [DATA_W-1:0] dataLinesIn
);

  // ----------------------------------------------------------------
  // Cycle counts for the chosen grade
  // ----------------------------------------------------------------
  localparam int G = (SLOW_GRADE != 0) ? 1 : 0;
  // Read sample point covers address and enable access, plus two sync stages
  localparam int RD_ACC = waitCycles(ADDRESS_TO_DATA_MAX_NS[G]);
  localparam int RD_OE = waitCycles(OE_TO_DATA_MAX_NS[G]);
  localparam int RD_WAIT = ((RD_ACC > RD_OE) ? RD_ACC : RD_OE) + 2;
  localparam int RD_CYC = minCycles(READ_CYCLE_MIN_NS[G]);
  localparam int RD_TOTAL = (RD_WAIT > RD_CYC) ? RD_WAIT : RD_CYC;
  localparam int WP_A = minCycles(WRITE_PULSE_MIN_NS[G]);
  localparam int WP_B = minCycles(CS_TO_WRITE_END_MIN_NS[G]);
  localparam int WP_C = minCycles(ADDR_TO_WRITE_END_MIN_NS[G]);
  localparam int WP_D = minCycles(DATA_SETUP_TO_WRITE_END_NS[G]);
  localparam int WP_AB = (WP_A > WP_B) ? WP_A : WP_B;
  localparam int WP_CD = (WP_C > WP_D) ? WP_C : WP_D;
  localparam int WP_TOTAL = (WP_AB > WP_CD) ? WP_AB : WP_CD;
  localparam int WC_CYC = minCycles(WRITE_CYCLE_MIN_NS[G]);
  // One cycle after strobes rise for the data hold; pads the cycle up to its minimum
  localparam int WE_TOTAL = (WC_CYC - WP_TOTAL > 1) ? (WC_CYC - WP_TOTAL) : 1;
  // Bus turn-around after a read before the host drives data
  localparam int TURN_CYC = waitCycles(RELEASE_MAX_NS[G]);

  localparam logic [3:0] RD_LAST = 4'(RD_TOTAL - 1);
  localparam logic [3:0] RD_SAMPLE = 4'(RD_WAIT - 1);
  localparam logic [3:0] WP_LAST = 4'(WP_TOTAL - 1);
  localparam logic [3:0] WE_LAST = 4'(WE_TOTAL - 1);
  localparam logic [3:0] TURN_LAST = 4'(TURN_CYC - 1);

  asrc_state_e state_reg;
  logic [3:0] cnt_reg;
  logic [DATA_W-1:0] dataSync;
  logic lastWasRead_reg;

  // ----------------------------------------------------------------
  // Pin input synchroniser
  // ----------------------------------------------------------------
  asrc_sync #(.WIDTH(DATA_W)) u_sync (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .din(dataLinesIn),
    .dout(dataSync)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_reg <= ASRC_IDLE;
      cnt_reg <= CNT_ZERO;
    end else begin
      case (state_reg)
        ASRC_IDLE: begin
          cnt_reg <= CNT_ZERO;
          if (reqValid && reqReady) begin
            if (!reqData.write) begin
              state_reg <= ASRC_RADDR;
            end else if (lastWasRead_reg) begin
              // Let the RAM release the bus before the host drives it
              state_reg <= ASRC_TURN;
            end else begin
              state_reg <= ASRC_WPULSE;
            end
          end
        end
        ASRC_RADDR: begin
          // Address held for the full read cycle
          if (cnt_reg == RD_LAST) begin
            state_reg <= ASRC_RDONE;
            cnt_reg <= CNT_ZERO;
          end else begin
            cnt_reg <= cnt_reg + CNT_ONE;
          end
        end
        ASRC_RDONE: begin
          state_reg <= ASRC_IDLE;
        end
        ASRC_TURN: begin
          if (cnt_reg == TURN_LAST) begin
            state_reg <= ASRC_WPULSE;
            cnt_reg <= CNT_ZERO;
          end else begin
            cnt_reg <= cnt_reg + CNT_ONE;
          end
        end
        ASRC_WPULSE: begin
          // Pulse covers pulse width, select, address and data setup minimums
          if (cnt_reg == WP_LAST) begin
            state_reg <= ASRC_WEND;
            cnt_reg <= CNT_ZERO;
          end else begin
            cnt_reg <= cnt_reg + CNT_ONE;
          end
        end
        ASRC_WEND: begin
          if (cnt_reg == WE_LAST) begin
            state_reg <= ASRC_IDLE;
            cnt_reg <= CNT_ZERO;
          end else begin
            cnt_reg <= cnt_reg + CNT_ONE;
          end
        end
        default: begin
          state_reg <= ASRC_IDLE;
          cnt_reg <= CNT_ZERO;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Request acceptance and bus direction history
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      reqReady <= 1'b0;
      lastWasRead_reg <= 1'b0;
    end else begin
      reqReady <= (state_reg == ASRC_IDLE) && !(reqValid && reqReady);
      if (state_reg == ASRC_RADDR) begin
        lastWasRead_reg <= 1'b1;
      end else if (state_reg == ASRC_WPULSE) begin
        lastWasRead_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin drive, all from flip-flops
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pins.addressLines <= '0;
      pins.chipSelN <= 1'b1;
      pins.writeStrobeN <= 1'b1;
      pins.outEnableN <= 1'b1;
      pins.dataLinesOut <= '0;
      pins.dataLinesOe <= 1'b0;
    end else begin
      if (state_reg == ASRC_IDLE && reqValid && reqReady) begin
        // Address and data set before or with the strobes
        pins.addressLines <= reqData.addr;
        pins.dataLinesOut <= reqData.wdata;
        if (!reqData.write) begin
          pins.chipSelN <= 1'b0;
          pins.outEnableN <= 1'b0;
        end else if (!lastWasRead_reg) begin
          // Select and strobe fall together so the write window is exact
          pins.chipSelN <= 1'b0;
          pins.writeStrobeN <= 1'b0;
          pins.dataLinesOe <= 1'b1;
        end
      end else if (state_reg == ASRC_TURN && cnt_reg == TURN_LAST) begin
        pins.chipSelN <= 1'b0;
        pins.writeStrobeN <= 1'b0;
        pins.dataLinesOe <= 1'b1;
      end else if (state_reg == ASRC_RADDR && cnt_reg == RD_LAST) begin
        pins.chipSelN <= 1'b1;
        pins.outEnableN <= 1'b1;
      end else if (state_reg == ASRC_WPULSE && cnt_reg == WP_LAST) begin
        // Strobes end the write; address and data kept one more cycle
        pins.chipSelN <= 1'b1;
        pins.writeStrobeN <= 1'b1;
      end else if (state_reg == ASRC_WEND && cnt_reg == WE_LAST) begin
        pins.dataLinesOe <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read data capture after the worst access time
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rspValid <= 1'b0;
      rspData <= '0;
    end else begin
      rspValid <= 1'b0;
      if (state_reg == ASRC_RADDR && cnt_reg == RD_SAMPLE) begin
        rspData <= dataSync;
        rspValid <= 1'b1;
      end
    end
  end

endmodule

// ---- tb/asrc_ctrl_props.sv ----
// Checker: pin timing and handshake assertions for the SRAM controller
`timescale 1ns/10ps
module asrc_ctrl_props
  import asrc_pkg::*;
#(
  parameter int SLOW_GRADE = 0
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // User side
  input wire logic reqValid,
  input wire asrc_req_s reqData,
  input wire logic reqReady,
  input wire logic rspValid,
  input wire logic [DATA_W-1:0] rspData,
  // SRAM side
  input wire asrc_pins_s pins,
  input wire logic [DATA_W-1:0] dataLinesIn
);
  // Read answer lag from the take edge, one more cycle on the slow grade
  localparam int RL = 9 + SLOW_GRADE;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // ----------------------------------------------------------------
  // Write cycle
  // ----------------------------------------------------------------
  property p_sel; !pins.writeStrobeN |-> !pins.chipSelN; endproperty
  a_sel: assert property (p_sel) else $error("strobe low without select");
  property p_pulse;
    $fell(pins.writeStrobeN) |-> (!pins.writeStrobeN && !pins.chipSelN)[*4];
  endproperty
  a_pulse: assert property (p_pulse) else $error("write pulse too short");
  property p_wdOe; !pins.writeStrobeN |-> pins.dataLinesOe; endproperty
  a_wdOe: assert property (p_wdOe) else $error("write data not driven");
  property p_stab;
    !pins.writeStrobeN && !$past(pins.writeStrobeN)
      |-> $stable(pins.dataLinesOut) && $stable(pins.addressLines);
  endproperty
  a_stab: assert property (p_stab) else $error("data or address moved in write");
  property p_hold; $rose(pins.writeStrobeN) |-> pins.dataLinesOe; endproperty
  a_hold: assert property (p_hold) else $error("write data dropped early");
  // ----------------------------------------------------------------
  // Read cycle and bus turnaround
  // ----------------------------------------------------------------
  property p_rdCyc;
    $fell(pins.chipSelN) && !pins.outEnableN |-> !pins.chipSelN[*6];
  endproperty
  a_rdCyc: assert property (p_rdCyc) else $error("read cycle too short");
  property p_clash; pins.dataLinesOe |-> pins.outEnableN; endproperty
  a_clash: assert property (p_clash) else $error("host drives while RAM enabled");
  property p_turn; $rose(pins.outEnableN) |-> !pins.dataLinesOe[*2]; endproperty
  a_turn: assert property (p_turn) else $error("no turnaround after read");
  property p_rsp; reqValid && reqReady && !reqData.write |-> ##RL rspValid; endproperty
  a_rsp: assert property (p_rsp) else $error("read answer late");
  c_read: cover property (rspValid);
  c_write: cover property ($rose(pins.writeStrobeN));
  c_turn: cover property ($rose(pins.outEnableN) ##[1:6] $fell(pins.writeStrobeN));
endmodule

bind asrc_ctrl asrc_ctrl_props #(.SLOW_GRADE(SLOW_GRADE)) u_props (.clk_sys(clk_sys),
  .nrst(nrst), .reqValid(reqValid), .reqData(reqData), .reqReady(reqReady),
  .rspValid(rspValid), .rspData(rspData), .pins(pins), .dataLinesIn(dataLinesIn));

// ---- tb/asrc_sram_model.sv ----
// Behavioural model of the asynchronous static RAM on the far side
`timescale 1ns/10ps
module asrc_sram_model
  import asrc_pkg::*;
#(
  parameter int ACC_NS = 55
) (
  // Pins from the controller
  input wire asrc_pins_s pins,
  input wire logic [DATA_W-1:0] busIn,
  // Drive back onto the data lines
  output logic [DATA_W-1:0] ramData,
  output logic ramOe
);
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic readEn;
  // Unwritten bytes read as a fixed filler pattern
  initial foreach (mem[i]) mem[i] = 8'h5a;
  // Drives only when selected, strobe high and output enabled
  assign readEn = !pins.chipSelN && pins.writeStrobeN && !pins.outEnableN;
  // On after 10 ns, off by 20 ns, so release always lags turn-on
  always @(readEn) ramOe <= #(readEn ? 10 : 20) readEn;
  // Old byte stays until the access time runs out
  always @(pins.addressLines or readEn) begin
    ramData <= #(ACC_NS) mem[pins.addressLines];
  end
  // Store through the overlap; the last level before write end wins
  always @(pins or busIn) begin
    if (!pins.chipSelN && !pins.writeStrobeN) mem[pins.addressLines] = busIn;
  end
endmodule

// ---- tb/testbench.sv ----
// Testbench: drives requests through the controller into the RAM model
`timescale 1ns/10ps
module testbench import asrc_pkg::*;;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic reqValid = 1'b0;
  asrc_req_s reqData = '0;
  logic reqReady, rspValid, ramOe;
  logic [DATA_W-1:0] rspData, ramData, bus;
  logic [DATA_W-1:0] flt = 8'h5a;
  asrc_pins_s pins;
  int n_errors = 0;
  int check_count = 0;
  // Ordinary cases; wdata doubles as the byte a read expects
  asrc_req_s rows [8] = '{'{1'b1, 19'h0, 8'ha5}, '{1'b1, 19'h7ffff, 8'h3c},
    '{1'b0, 19'h0, 8'ha5}, '{1'b0, 19'h7ffff, 8'h3c}, '{1'b1, 19'h12345, 8'hff},
    '{1'b0, 19'h12345, 8'hff}, '{1'b1, 19'h12345, 8'h00}, '{1'b0, 19'h12345, 8'h00}};
  // ----------------------------------------------------------------
  // Clock, bus resolution and instances
  // ----------------------------------------------------------------
  initial forever #5 clk_sys = ~clk_sys;
  // A released bus shows a changing pattern, never the last value
  always @(posedge clk_sys) flt <= ~flt;
  assign bus = pins.dataLinesOe ? pins.dataLinesOut : (ramOe ? ramData : flt);
  asrc_ctrl #(.SLOW_GRADE(0)) dut (.clk_sys(clk_sys), .nrst(nrst), .reqValid(reqValid),
    .reqData(reqData), .reqReady(reqReady), .rspValid(rspValid), .rspData(rspData),
    .pins(pins), .dataLinesIn(bus));
  asrc_sram_model ram (.pins(pins), .busIn(bus), .ramData(ramData), .ramOe(ramOe));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One request, held until taken; waits are bounded so a hang cannot stall
  task automatic doOp(input asrc_req_s r);
    int n;
    n = 0;
    reqData = r;
    reqValid = 1'b1;
    while (reqReady !== 1'b1 && n < 40) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    @(posedge clk_sys);
    #1;
    reqValid = 1'b0;
    // Let an edge pass so a following request never reuses this time step
    @(posedge clk_sys);
    #1;
    n = 0;
    while ((r.write ? pins.writeStrobeN : rspValid) !== !r.write && n < 40) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (r.write) begin
      check(bus, r.wdata);
      check(pins.addressLines, r.addr);
    end else begin
      check(rspValid, 1'b1);
      check(rspData, r.wdata);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk_sys);
    #1;
    check({pins.chipSelN, pins.writeStrobeN, pins.outEnableN, pins.dataLinesOe}, 4'he);
    nrst = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    $display("reset test done");
    foreach (rows[i]) doOp(rows[i]);
    $display("table test done");
    // Reset in mid-read: pins fall idle at once and the bus is let go
    reqData = rows[3];
    reqValid = 1'b1;
    repeat (4) @(posedge clk_sys);
    #1;
    check(pins.chipSelN, 1'b0);
    nrst = 1'b0;
    reqValid = 1'b0;
    #1;
    check({pins.chipSelN, pins.writeStrobeN, pins.outEnableN, pins.dataLinesOe}, 4'he);
    check(reqReady, 1'b0);
    repeat (2) @(posedge clk_sys);
    #1;
    nrst = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    doOp(rows[3]);
    $display("mid-read reset test done");
    final_report;
  end
  // Whole run needs about 1 us; twenty times that means a hang
  initial begin
    #20000;
    n_errors++;
    final_report;
  end
endmodule
